// [hw/radio_mode_pkg.sv]
// constants and types shared by both ends of the radio mode link
// assumes a 200 MHz system clock on both ends
package radio_mode_pkg;
  localparam int clk_mhz = 200;
  // settling and pulse times, in microseconds as printed
  localparam int standby_to_active_delay_us = 210;
  localparam int gain_settle_us = 20;
  localparam int activate_min_us = 20;
  localparam int cs_after_activate_us = 4;
  localparam int powerdown_to_standby_delay_us = 2000;
  localparam int settle_cycles = standby_to_active_delay_us * clk_mhz;
  localparam int gain_cycles = gain_settle_us * clk_mhz;
  localparam int activate_cycles = activate_min_us * clk_mhz;
  localparam int cs_cycles = cs_after_activate_us * clk_mhz;
  localparam int pd2stby_cycles = powerdown_to_standby_delay_us * clk_mhz;
  localparam int packet_cycles_default = 64;
  // device register map (byte index on the link)
  localparam logic [7:0] config_addr = 8'h00;
  localparam logic [7:0] channel_addr = 8'h05;
  localparam logic [7:0] radio_setup_addr = 8'h06;
  localparam logic [7:0] power_level_addr = 8'h09;
  localparam logic [7:0] tx_load_addr = 8'hA0;
  localparam int power_on_pos = 1;
  localparam int receive_role_pos = 0;
  localparam int rate_lsb = 4;
  localparam int tx_power_lsb = 0;
  // air rate codes; 2'b11 is reserved
  localparam logic [1:0] rate_500k = 2'h0;
  localparam logic [1:0] rate_1m = 2'h1;
  localparam logic [1:0] rate_2m = 2'h2;
  localparam logic [7:0] config_reset = 8'h00;
  localparam logic [7:0] channel_reset = 8'h02;
  localparam logic [7:0] radio_setup_reset = 8'h1F;
  localparam logic [7:0] power_floor = 8'h9C;
  localparam logic [7:0] power_ceiling = 8'h0A;
  localparam int tx_depth = 3;
  // host APB register offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] setup_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;
  localparam logic [7:0] level_off = 8'h0C;
  localparam int ctrl_go_pos = 0;
  localparam int ctrl_hold_pos = 1;
  localparam int ctrl_load_pos = 2;
  localparam int ctrl_write_pos = 3;
  typedef enum logic [2:0] {
    mode_reset = 3'b000,
    mode_powerdown = 3'b001,
    mode_standby1 = 3'b011,
    mode_settle = 3'b010,
    mode_tx = 3'b110,
    mode_rx = 3'b111,
    mode_standby2 = 3'b101
  } mode_type;
endpackage

// [hw/radio_link_if.sv]
// link between host controller and radio: activate pin plus a
// simple strobed register port standing in for the serial port
`timescale 1ns/1ps
interface radio_link_if;
  logic activate; // activate pin, host driven
  logic cs_n; // chip select, low during an access
  logic wr; // write strobe, pulse while cs_n low
  logic [7:0] addr; // register index
  logic [7:0] wdata; // write data
  logic [7:0] rdata; // read data from device
  logic tx_empty; // device transmit fifo empty
  logic [2:0] mode; // device mode code
  modport device (input activate, cs_n, wr, addr, wdata,
    output rdata, tx_empty, mode);
  modport host (output activate, cs_n, wr, addr, wdata,
    input rdata, tx_empty, mode);
endinterface

// [hw/radio_mode_device.sv]
// operating-mode controller of the radio transceiver end
// link inputs come from another clock domain and are synchronised
`timescale 1ns/1ps
module radio_mode_device (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  radio_link_if.device link, // host side link
  input wire logic rx_packet, // pulse: valid packet received
  input wire logic [7:0] rx_power, // raw received power, signed
  output logic [11:0] carrier_mhz, // carrier frequency
  output logic [1:0] air_rate, // selected air rate
  output logic [3:0] tx_power_level, // selected output power
  output logic rate_valid, // air rate code is not reserved
  output logic tx_done, // pulse: packet sent
  output logic rx_stored, // pulse: packet stored
  output logic rx_dropped, // pulse: packet dropped
  output logic [1:0] rx_count // packets held in receive fifo
);
  localparam int packet_cycles = radio_mode_pkg::packet_cycles_default;

  ////////////////////////////////////////////////////////////////////
  // two-flop synchronisers on every link input
  logic [11:0] sync1;
  logic [11:0] sync2;
  logic activate_s;
  logic cs_n_s;
  logic wr_s;
  logic wr_prev;
  logic cs_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // chip select resets to its idle high level, so no false rise
      sync1 <= 12'h300;
      sync2 <= 12'h300;
    end else begin
      sync1 <= {link.activate, link.wr, link.cs_n, 1'b1, link.addr};
      sync2 <= sync1;
    end
  end
  assign activate_s = sync2[11];
  assign wr_s = sync2[10];
  assign cs_n_s = sync2[9];

  ////////////////////////////////////////////////////////////////////
  // register writes are taken on the rising edge of the strobe;
  // address and data are held steady by the host around it
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] wdata_s;
  logic [7:0] config_reg;
  logic [7:0] channel_number;
  logic [7:0] radio_setup_reg;
  logic [1:0] tx_fill;
  logic wr_edge;
  logic load_edge;
  logic cs_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_q <= 8'h00;
      wdata_s <= 8'h00;
      wr_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      wdata_q <= link.wdata;
      wdata_s <= wdata_q;
      wr_prev <= wr_s;
      cs_prev <= cs_n_s;
    end
  end
  assign addr_q = sync2[7:0];
  assign wr_edge = wr_s && !wr_prev;
  assign load_edge = wr_edge && (addr_q == radio_mode_pkg::tx_load_addr);
  assign cs_rise = cs_n_s && !cs_prev;

  // port works in every mode, power-down included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= radio_mode_pkg::config_reset;
      channel_number <= radio_mode_pkg::channel_reset;
      radio_setup_reg <= radio_mode_pkg::radio_setup_reset;
    end else if (wr_edge) begin
      case (addr_q)
        radio_mode_pkg::config_addr: config_reg <= wdata_s;
        radio_mode_pkg::channel_addr: channel_number <= wdata_s;
        radio_mode_pkg::radio_setup_addr: radio_setup_reg <= wdata_s;
        default: config_reg <= config_reg;
      endcase
    end
  end

  logic power_on_bit;
  logic receive_role_select;
  assign power_on_bit = config_reg[radio_mode_pkg::power_on_pos];
  assign receive_role_select = config_reg[radio_mode_pkg::receive_role_pos];
  assign air_rate = radio_setup_reg[radio_mode_pkg::rate_lsb +: 2];
  assign rate_valid = (air_rate != 2'h3);
  assign tx_power_level = radio_setup_reg[radio_mode_pkg::tx_power_lsb +: 4];
  assign carrier_mhz = 12'h960 + {4'h0, channel_number};

  ////////////////////////////////////////////////////////////////////
  // mode state machine with one shared settle timer
  radio_mode_pkg::mode_type mode;
  radio_mode_pkg::mode_type next_mode;
  logic [15:0] timer;
  logic [15:0] next_timer;
  logic settle_to_rx;
  logic next_settle_to_rx;
  logic pending_send; // an upload seen in standby-II (cs rise starts it)
  logic timer_done;
  logic tx_fin;
  assign timer_done = (timer == 16'h0000);
  assign tx_fin = (mode == radio_mode_pkg::mode_tx) && timer_done;

  always_comb begin
    next_mode = mode;
    next_timer = (timer == 16'h0000) ? 16'h0000 : timer - 16'h0001;
    next_settle_to_rx = settle_to_rx;
    if (!power_on_bit && mode != radio_mode_pkg::mode_reset) begin
      next_mode = radio_mode_pkg::mode_powerdown;
    end else begin
      case (mode)
        radio_mode_pkg::mode_reset:
          next_mode = radio_mode_pkg::mode_powerdown;
        radio_mode_pkg::mode_powerdown:
          next_mode = radio_mode_pkg::mode_standby1;
        radio_mode_pkg::mode_standby1: begin
          if (activate_s && receive_role_select) begin
            next_mode = radio_mode_pkg::mode_settle;
            next_settle_to_rx = 1'b1;
            next_timer = 16'(radio_mode_pkg::settle_cycles - 1);
          end else if (activate_s && tx_fill != 2'h0) begin
            next_mode = radio_mode_pkg::mode_settle;
            next_settle_to_rx = 1'b0;
            next_timer = 16'(radio_mode_pkg::settle_cycles - 1);
          end else if (activate_s) begin
            next_mode = radio_mode_pkg::mode_standby2;
          end
        end
        radio_mode_pkg::mode_settle: begin
          if (!activate_s && settle_to_rx) begin
            next_mode = radio_mode_pkg::mode_standby1;
          end else if (timer_done) begin
            if (settle_to_rx) begin
              next_mode = radio_mode_pkg::mode_rx;
              next_timer = 16'(radio_mode_pkg::gain_cycles - 1);
            end else begin
              next_mode = radio_mode_pkg::mode_tx;
              next_timer = 16'(packet_cycles - 1);
            end
          end
        end
        radio_mode_pkg::mode_tx: begin
          if (timer_done) begin
            if (!activate_s) begin
              next_mode = radio_mode_pkg::mode_standby1;
            end else if (tx_fill > 2'h1) begin
              next_timer = 16'(packet_cycles - 1);
            end else begin
              next_mode = radio_mode_pkg::mode_standby2;
            end
          end
        end
        radio_mode_pkg::mode_rx: begin
          if (!activate_s || !receive_role_select) begin
            next_mode = radio_mode_pkg::mode_standby1;
          end
        end
        radio_mode_pkg::mode_standby2: begin
          if (!activate_s) begin
            next_mode = radio_mode_pkg::mode_standby1;
          end else if (pending_send && cs_rise) begin
            next_mode = radio_mode_pkg::mode_settle;
            next_settle_to_rx = 1'b0;
            next_timer = 16'(radio_mode_pkg::settle_cycles - 1);
          end
        end
        default: next_mode = radio_mode_pkg::mode_powerdown;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= radio_mode_pkg::mode_reset;
      timer <= 16'h0000;
      settle_to_rx <= 1'b0;
    end else begin
      mode <= next_mode;
      timer <= next_timer;
      settle_to_rx <= next_settle_to_rx;
    end
  end

  // upload seen while idling in standby-II waits for chip select rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_send <= 1'b0;
    end else if (mode != radio_mode_pkg::mode_standby2) begin
      pending_send <= 1'b0;
    end else if (load_edge) begin
      pending_send <= 1'b1;
    end
  end

  // transmit fifo level: loads add, finished packets remove
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_fill <= 2'h0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= tx_fin;
      if (load_edge && !tx_fin && tx_fill != 2'(radio_mode_pkg::tx_depth)) begin
        tx_fill <= tx_fill + 2'h1;
      end else if (tx_fin && !load_edge) begin
        tx_fill <= tx_fill - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive fifo occupancy and power level capture
  logic in_rx;
  logic level_valid;
  logic [7:0] received_power_level;
  logic [7:0] clamped_power;
  assign in_rx = (mode == radio_mode_pkg::mode_rx);
  assign level_valid = in_rx && timer_done;
  // clamp to the documented signed span, power_floor up to power_ceiling
  assign clamped_power =
    ($signed(rx_power) < $signed(radio_mode_pkg::power_floor)) ?
      radio_mode_pkg::power_floor :
    ($signed(rx_power) > $signed(radio_mode_pkg::power_ceiling)) ?
      radio_mode_pkg::power_ceiling : rx_power;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_count <= 2'h0;
      rx_stored <= 1'b0;
      rx_dropped <= 1'b0;
      received_power_level <= 8'h00;
    end else begin
      rx_stored <= in_rx && rx_packet &&
        rx_count != 2'(radio_mode_pkg::tx_depth);
      rx_dropped <= in_rx && rx_packet &&
        rx_count == 2'(radio_mode_pkg::tx_depth);
      if (in_rx && rx_packet && rx_count != 2'(radio_mode_pkg::tx_depth)) begin
        rx_count <= rx_count + 2'h1;
      end
      if (level_valid) begin
        received_power_level <= clamped_power;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data and status back to the host, registered
  logic [7:0] read_mux;
  assign read_mux =
    (addr_q == radio_mode_pkg::config_addr) ? config_reg :
    (addr_q == radio_mode_pkg::channel_addr) ? channel_number :
    (addr_q == radio_mode_pkg::radio_setup_addr) ? radio_setup_reg :
    (addr_q == radio_mode_pkg::power_level_addr) ?
      received_power_level : 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rdata <= 8'h00;
      link.tx_empty <= 1'b1;
      link.mode <= 3'h0;
    end else begin
      link.rdata <= read_mux;
      link.tx_empty <= (tx_fill == 2'h0);
      link.mode <= mode;
    end
  end
endmodule

// [hw/radio_mode_host.sv]
// host controller end: APB registers drive the link to the radio
// assumes radio status lines arrive from another clock domain
`timescale 1ns/1ps
module radio_mode_host (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  radio_link_if.host link // radio side link
);
  ////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped offsets answer pslverr
  logic [31:0] setup; // [15:8] register index, [7:0] data
  logic [7:0] level; // last read byte
  logic busy;
  logic hold_mode;
  logic go_req;
  logic write_req;
  logic load_req;
  logic acc_wr;
  logic hit_ctrl;
  logic hit_setup;
  logic hit_status;
  logic hit_level;
  logic mapped;
  logic asleep;
  assign acc_wr = psel && penable && pwrite;
  assign hit_ctrl = (paddr == radio_mode_pkg::ctrl_off);
  assign hit_setup = (paddr == radio_mode_pkg::setup_off);
  assign hit_status = (paddr == radio_mode_pkg::status_off);
  assign hit_level = (paddr == radio_mode_pkg::level_off);
  assign mapped = hit_ctrl || hit_setup || hit_status || hit_level;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////
  // two-flop synchronisers on device status
  logic [11:0] st1;
  logic [11:0] st2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st1 <= 12'h000;
      st2 <= 12'h000;
    end else begin
      st1 <= {link.tx_empty, link.mode, link.rdata};
      st2 <= st1;
    end
  end
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_ctrl) prdata = {30'h0, hold_mode, busy};
    else if (hit_setup) prdata = setup;
    else if (hit_status) prdata = {28'h0, st2[11:8]};
    else if (hit_level) prdata = {24'h0, level};
  end

  ////////////////////////////////////////////////////////////////////
  // link sequencer: register write, fifo load, activate pulse
  typedef enum logic [2:0] {
    seq_idle = 3'b000,
    seq_strobe = 3'b001,
    seq_release = 3'b011,
    seq_activate = 3'b010,
    seq_guard = 3'b110
  } seq_type;
  seq_type seq;
  logic [15:0] cnt;
  logic pulse_mode;
  assign busy = (seq != seq_idle);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup <= 32'h0000_0000;
      hold_mode <= 1'b0;
    end else if (acc_wr && hit_setup) begin
      setup <= pwdata;
    end else if (acc_wr && hit_ctrl) begin
      hold_mode <= pwdata[radio_mode_pkg::ctrl_hold_pos];
    end
  end
  // go is refused while the radio reports power-down or reset, so the
  // activate pin never rises before the radio has left power-down
  assign asleep = (st2[10:8] == radio_mode_pkg::mode_powerdown) ||
    (st2[10:8] == radio_mode_pkg::mode_reset);
  assign go_req = acc_wr && hit_ctrl && !busy && !asleep &&
    pwdata[radio_mode_pkg::ctrl_go_pos];
  assign load_req = acc_wr && hit_ctrl && !busy &&
    pwdata[radio_mode_pkg::ctrl_load_pos];
  assign write_req = acc_wr && hit_ctrl && !busy &&
    pwdata[radio_mode_pkg::ctrl_write_pos];

  // strobes are held 4 cycles so the far end's synchronisers see them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= seq_idle;
      cnt <= 16'h0000;
      pulse_mode <= 1'b0;
      level <= 8'h00;
      link.activate <= 1'b0;
      link.cs_n <= 1'b1;
      link.wr <= 1'b0;
      link.addr <= 8'h00;
      link.wdata <= 8'h00;
    end else begin
      case (seq)
        seq_idle: begin
          link.activate <= hold_mode && link.activate;
          if (write_req || load_req) begin
            link.addr <= load_req ? radio_mode_pkg::tx_load_addr :
              setup[15:8];
            link.wdata <= setup[7:0];
            link.cs_n <= 1'b0;
            cnt <= 16'h0008;
            seq <= seq_strobe;
          end else if (go_req) begin
            link.activate <= 1'b1;
            cnt <= 16'(radio_mode_pkg::activate_cycles + 8);
            // take hold from the same write, not the stale register
            pulse_mode <= !pwdata[radio_mode_pkg::ctrl_hold_pos];
            seq <= seq_activate;
          end
        end
        seq_strobe: begin
          link.wr <= (cnt < 16'h0006) && (cnt > 16'h0001);
          cnt <= cnt - 16'h0001;
          if (cnt == 16'h0000) seq <= seq_release;
        end
        seq_release: begin
          link.cs_n <= 1'b1;
          level <= st2[7:0];
          seq <= seq_idle;
        end
        seq_activate: begin
          cnt <= cnt - 16'h0001;
          if (cnt == 16'h0000) begin
            link.activate <= !pulse_mode;
            cnt <= 16'(radio_mode_pkg::cs_cycles);
            seq <= seq_guard;
          end
        end
        seq_guard: begin
          cnt <= cnt - 16'h0001;
          if (cnt == 16'h0000) seq <= seq_idle;
        end
        default: seq <= seq_idle;
      endcase
    end
  end
endmodule

// [test/radio_link_properties.sv]
// concurrent checks on the link between host end and device end
// assumes it sits beside the link interface, all on pclk
`timescale 1ns/1ps
module radio_link_properties (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic activate, // activate pin
  input wire logic wr, // link write strobe
  input wire logic [7:0] addr, // link register index
  input wire logic [7:0] wdata, // link write data
  input wire logic tx_empty, // device transmit fifo empty
  input wire logic [2:0] mode // device mode code
);
  localparam int settle_max = radio_mode_pkg::settle_cycles;
  int settle_cnt;
  // decoded views of the link, shared by several checks
  wire logic in_settle = (mode == radio_mode_pkg::mode_settle);
  wire logic cfg_wr = wr && (addr == radio_mode_pkg::config_addr);
  wire logic pwr_bit = wdata[radio_mode_pkg::power_on_pos];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////
  // settle length; too big for a repetition, so it is counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 0;
    end else begin
      settle_cnt <= in_settle ? settle_cnt + 1 : 0;
    end
  end
  // mode sequencing, tied to link writes and the activate pin
  // the mode code on the link lags the state register by one cycle
  reset_exit_a: assert property (
    mode == radio_mode_pkg::mode_reset ##1
    mode == radio_mode_pkg::mode_reset |=>
    mode == radio_mode_pkg::mode_powerdown) else $error("bad reset exit");
  power_off_a: assert property ($rose(cfg_wr) && !pwr_bit |->
    ##[1:16] mode == radio_mode_pkg::mode_powerdown)
    else $error("power-down not entered");
  power_on_a: assert property ($rose(cfg_wr) && pwr_bit &&
    mode == radio_mode_pkg::mode_powerdown |->
    ##[1:16] mode == radio_mode_pkg::mode_standby1)
    else $error("standby-I not entered");
  settle_entry_a: assert property ($rose(in_settle) |->
    $past(activate, 2) || $past(activate, 3) || $past(activate, 4))
    else $error("settle without activate");
  rx_release_a: assert property ((!activate) [*6] |->
    mode != radio_mode_pkg::mode_rx) else $error("rx kept after release");
  settle_bound_a: assert property (settle_cnt <= settle_max)
    else $error("settle too long");
  active_entry_a: assert property ($changed(mode) &&
    (mode == radio_mode_pkg::mode_tx || mode == radio_mode_pkg::mode_rx)
    |-> $past(mode) == radio_mode_pkg::mode_settle)
    else $error("active mode not via settle");
  standby2_entry_a: assert property (
    $rose(mode == radio_mode_pkg::mode_standby2) |-> tx_empty)
    else $error("standby-II with data queued");
  tx_finish_a: assert property ($past(mode) == radio_mode_pkg::mode_tx &&
    mode != radio_mode_pkg::mode_tx && !activate && !$past(activate, 3)
    |-> mode == radio_mode_pkg::mode_standby1)
    else $error("tx end not to standby-I");
endmodule

// [test/test_radio_mode_controller.sv]
// self-checking bench: apb host end driving the device end
// assumes zero-wait apb slave and a free-running 200 MHz clock
`timescale 1ns/1ps
module test_radio_mode_controller;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [7:0] rx_power;
  logic [31:0] pwdata, prdata, rd;
  logic rx_packet, rate_valid, tx_done, rx_stored, rx_dropped;
  logic [11:0] carrier_mhz;
  logic [1:0] air_rate, rx_count;
  logic [3:0] tx_power_level;
  logic [3:0] pw [4] = '{4'hF, 4'h3, 4'h0, 4'h8};
  int fails = 0, compares = 0, cycles = 0, n_tx = 0, n_st = 0, n_dr = 0;
  radio_link_if link();
  radio_mode_host radio_mode_host_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  radio_mode_device radio_mode_device_inst (.pclk(pclk),
    .presetn(presetn), .link(link), .rx_packet(rx_packet),
    .rx_power(rx_power), .carrier_mhz(carrier_mhz), .air_rate(air_rate),
    .tx_power_level(tx_power_level), .rate_valid(rate_valid),
    .tx_done(tx_done), .rx_stored(rx_stored), .rx_dropped(rx_dropped),
    .rx_count(rx_count));
  radio_link_properties radio_link_properties_inst (.pclk(pclk),
    .presetn(presetn), .activate(link.activate), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .tx_empty(link.tx_empty),
    .mode(link.mode));
  ////////////////////////////////////////////////////////////////////
  // clock; 200 MHz
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  // pulse counters and a hang limit sized for both long settles
  always @(posedge pclk) begin
    cycles++;
    if (tx_done === 1'h1) n_tx++;
    if (rx_stored === 1'h1) n_st++;
    if (rx_dropped === 1'h1) n_dr++;
    if (cycles == 99000) begin
      fails++;
      $display("[ERR] run expected done seen timeout");
      close_out();
    end
  end
  // verdict and end of run
  task close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; an idle cycle follows so psel never toggles twice
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // commands are refused while busy, so poll before going on
  task idle();
    do apb(1'h0, radio_mode_pkg::ctrl_off, 32'h0);
    while (rd[0] !== 1'h0);
  endtask
  task link_put(input logic [7:0] idx, input logic [7:0] val);
    apb(1'h1, radio_mode_pkg::setup_off, {16'h0, idx, val});
    apb(1'h1, radio_mode_pkg::ctrl_off, 32'h8);
    idle();
  endtask
  task status(input logic [31:0] exp);
    apb(1'h0, radio_mode_pkg::status_off, 32'h0);
    chk("status", exp, rd);
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence: reset, setup, power, one tx pulse, rx with hold
  initial begin
    {psel, penable, pwrite, rx_packet, presetn} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rx_power = 8'h20;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    status(32'h9);
    apb(1'h0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset done");
    link_put(radio_mode_pkg::channel_addr, 8'h10);
    chk("carrier", 32'h970, {20'h0, carrier_mhz});
    for (int i = 0; i < 4; i++) begin
      link_put(radio_mode_pkg::radio_setup_addr, {2'h0, i[1:0], pw[i]});
      chk("rate", i, {30'h0, air_rate});
      chk("power", {28'h0, pw[i]}, {28'h0, tx_power_level});
      chk("valid", {31'h0, i != 3}, {31'h0, rate_valid});
    end
    $display("test setup done");
    link_put(radio_mode_pkg::config_addr, 8'h02);
    status(32'hB);
    link_put(radio_mode_pkg::config_addr, 8'h00);
    status(32'h9);
    $display("test power done");
    link_put(radio_mode_pkg::config_addr, 8'h02);
    apb(1'h1, radio_mode_pkg::ctrl_off, 32'h4);
    idle();
    status(32'h3);
    apb(1'h1, radio_mode_pkg::ctrl_off, 32'h1);
    while (n_tx == 0) @(posedge pclk);
    repeat (1000) @(posedge pclk);
    chk("packets", 32'h1, n_tx);
    status(32'hB);
    $display("test tx done");
    // activate held with an empty fifo parks the transmitter
    apb(1'h1, radio_mode_pkg::ctrl_off, 32'h3);
    idle();
    status(32'hD);
    $display("test standby done");
    link_put(radio_mode_pkg::config_addr, 8'h03);
    apb(1'h1, radio_mode_pkg::ctrl_off, 32'h3);
    while (link.mode !== radio_mode_pkg::mode_rx) @(posedge pclk);
    repeat (radio_mode_pkg::gain_cycles + 100) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      rx_packet <= 1'h1;
      @(posedge pclk);
      rx_packet <= 1'h0;
      repeat (4) @(posedge pclk);
    end
    chk("stored", 32'h3, n_st);
    chk("dropped", 32'h1, n_dr);
    chk("fill", 32'h3, {30'h0, rx_count});
    idle();
    // status first: the fetch below clears hold and drops activate
    status(32'hF);
    link_put(radio_mode_pkg::power_level_addr, 8'h00);
    apb(1'h0, radio_mode_pkg::level_off, 32'h0);
    chk("level", 32'hA, rd);
    $display("test rx done");
    close_out();
  end
endmodule
